/* rtl/lin_phy_status_routing.sv */
// lin physical-layer fault flags, line status and tx/rx routing
// assumes the register master and the port/uart logic share ref_clk_in;
// transceiver sense lines arrive asynchronous and are synchronised here
//
// The strobed register port is this design's own decision.
`default_nettype none
`timescale 1ns/100ps

// Operation
// - latch overtemp flag until software writes one
// - latch stuck-dominant flag, cleared by writing one
// - latch rf disturbance flag, cleared by writing one
// - latch undervoltage flag, cleared by writing one
// - fault register bits are write-one-to-clear
// - transmitter ready shown as read-only bit
// - receive line state read-only, one is dominant
// - transmit line state read-only, one is dominant
// - port source select drives transmitter from port
// - uart source select drives transmitter from uart
// - both sources selected, uart wins
// - receive-to-port bit connects receiver to port
// - receive-to-uart bit connects receiver to uart
// - decode offsets from blocking and non-blocking base
// - overtemp flag interrupts only when enabled
// - stuck-dominant flag interrupts only when enabled
// - undervoltage without keep-alive forces bus recessive
module lin_phy_status_routing
    import lin_phy_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire reg_req_type req_in,
    output logic [7:0] rdata_out,
    input wire phy_sense_type sense_in,
    input wire logic port_tx_in,
    input wire logic uart_tx_in,
    input wire logic overtemp_irq_enable_in,
    input wire logic stuck_dominant_irq_enable_in,
    input wire logic low_supply_keep_alive_in,
    output logic lin_tx_out,
    output logic port_rx_out,
    output logic uart_rx_out,
    output logic irq_out
);

    // ==========================================================
    // synchronised transceiver sense
    logic [SENSE_W-1:0] sense_raw;
    phy_sense_type sense_s;

    level_sync #(
        .WIDTH(SENSE_W)
    ) u_sense_sync (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .async_in(sense_in),
        .sync_out(sense_raw)
    );

    assign sense_s = phy_sense_type'(sense_raw);

    // ==========================================================
    // address decode
    logic hit;
    logic [7:0] ofs;
    logic wr_fault;
    logic wr_tx_sel;
    logic wr_rx_sel;

    always_comb begin
        hit = ((req_in.addr & BASE_MASK) == BLOCKING_BASE)
            || ((req_in.addr & BASE_MASK) == NONBLOCKING_BASE);
        ofs = req_in.addr[7:0];
        wr_fault = req_in.wr && hit && (ofs == OFS_FAULT);
        wr_tx_sel = req_in.wr && hit && (ofs == OFS_TX_SEL);
        wr_rx_sel = req_in.wr && hit && (ofs == OFS_RX_SEL);
    end

    // ==========================================================
    // fault flags and routing selects
    logic [7:0] fault_q;
    logic [7:0] fault_d;
    logic [7:0] fault_set;
    logic [7:0] fault_clr;
    logic [1:0] tx_sel_q;
    logic [1:0] tx_sel_d;
    logic [1:0] rx_sel_q;
    logic [1:0] rx_sel_d;

    always_comb begin
        fault_set = 8'h00;
        fault_set[OT_BIT] = sense_s.overtemp;
        fault_set[DOM_BIT] = sense_s.stuck_dom;
        fault_set[RF_BIT] = sense_s.rf_dist;
        fault_set[UV_BIT] = sense_s.undervolt;
        fault_clr = wr_fault ? req_in.wdata : 8'h00;
        // set wins over clear so an event in the clearing cycle is kept
        fault_d = (fault_q & ~fault_clr) | fault_set;
        tx_sel_d = wr_tx_sel ? req_in.wdata[1:0] : tx_sel_q;
        rx_sel_d = wr_rx_sel ? req_in.wdata[1:0] : rx_sel_q;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fault_q <= FAULT_RESET;
            tx_sel_q <= SEL_RESET;
            rx_sel_q <= SEL_RESET;
        end else begin
            fault_q <= fault_d;
            tx_sel_q <= tx_sel_d;
            rx_sel_q <= rx_sel_d;
        end
    end

    // ==========================================================
    // read path, data valid only in the cycle after the strobe
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;

    always_comb begin
        rdata_d = 8'h00;
        if (req_in.rd && hit) begin
            case (ofs)
                OFS_FAULT: begin
                    rdata_d = fault_q;
                end
                OFS_LINE: begin
                    rdata_d[RDY_BIT] = sense_s.tx_ready;
                    rdata_d[RX_BIT] = sense_s.rx_dom;
                    rdata_d[TX_BIT] = sense_s.tx_dom;
                end
                OFS_TX_SEL: begin
                    rdata_d[1:0] = tx_sel_q;
                end
                OFS_RX_SEL: begin
                    rdata_d[1:0] = rx_sel_q;
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    // ==========================================================
    // line routing and interrupt
    logic lin_tx_d;
    logic lin_tx_q;
    logic port_rx_d;
    logic port_rx_q;
    logic uart_rx_d;
    logic uart_rx_q;
    logic irq_d;
    logic irq_q;
    logic uv_block;

    always_comb begin
        // disconnected paths idle recessive (zero)
        uv_block = sense_s.undervolt && !low_supply_keep_alive_in;
        if (tx_sel_q[SRC_UART_BIT]) begin
            lin_tx_d = uart_tx_in;
        end else if (tx_sel_q[SRC_PORT_BIT]) begin
            lin_tx_d = port_tx_in;
        end else begin
            lin_tx_d = 1'b0;
        end
        if (uv_block) begin
            lin_tx_d = 1'b0;
        end
        // both destinations may be open at once
        port_rx_d = rx_sel_q[DST_PORT_BIT] && sense_s.rx_dom;
        uart_rx_d = rx_sel_q[DST_UART_BIT] && sense_s.rx_dom;
        irq_d = (fault_q[OT_BIT] && overtemp_irq_enable_in)
            || (fault_q[DOM_BIT] && stuck_dominant_irq_enable_in);
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= RDATA_RESET;
            lin_tx_q <= 1'b0;
            port_rx_q <= 1'b0;
            uart_rx_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            lin_tx_q <= lin_tx_d;
            port_rx_q <= port_rx_d;
            uart_rx_q <= uart_rx_d;
            irq_q <= irq_d;
        end
    end

    assign rdata_out = rdata_q;
    assign lin_tx_out = lin_tx_q;
    assign port_rx_out = port_rx_q;
    assign uart_rx_out = uart_rx_q;
    assign irq_out = irq_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    overtemp_latch_a: assert property (
        sense_s.overtemp |=> fault_q[OT_BIT] ##1 (fault_q[OT_BIT] || $past(wr_fault)))
        else $error("overtemp flag not latched");

    stuck_dom_hold_a: assert property (
        (fault_q[DOM_BIT] && !(wr_fault && req_in.wdata[DOM_BIT])) |=> fault_q[DOM_BIT])
        else $error("stuck dominant flag lost without clear");

    rf_flag_set_a: assert property (
        sense_s.rf_dist |=> fault_q[RF_BIT])
        else $error("rf disturbance flag not set");

    uv_flag_set_a: assert property (
        sense_s.undervolt |=> fault_q[UV_BIT])
        else $error("undervoltage flag not set");

    fault_clear_a: assert property (
        (wr_fault && req_in.wdata[OT_BIT] && !sense_s.overtemp) |=> !fault_q[OT_BIT])
        else $error("write one did not clear overtemp flag");

    line_read_a: assert property (
        (req_in.rd && hit && ofs == OFS_LINE)
        |=> rdata_out == {$past(sense_s.tx_ready), 5'h00, $past(sense_s.rx_dom), $past(sense_s.tx_dom)})
        else $error("line status read wrong");

    tx_priority_a: assert property (
        (tx_sel_q == 2'h3 && !uv_block) |=> lin_tx_out == $past(uart_tx_in))
        else $error("uart did not win transmit source");

    tx_port_path_a: assert property (
        (tx_sel_q == 2'h2 && !uv_block) |=> lin_tx_out == $past(port_tx_in))
        else $error("port did not drive transmitter");

    rx_fanout_a: assert property (
        (rx_sel_q == 2'h3) |=> (port_rx_out == $past(sense_s.rx_dom)) && (uart_rx_out == $past(sense_s.rx_dom)))
        else $error("receiver fan-out wrong");

    uv_recessive_a: assert property (
        uv_block |=> !lin_tx_out)
        else $error("bus not held recessive in undervoltage");

    irq_gate_a: assert property (
        (!overtemp_irq_enable_in && !stuck_dominant_irq_enable_in) |=> !irq_out)
        else $error("interrupt raised while disabled");

    fault_reserved_a: assert property (
        (req_in.rd && hit && ofs == OFS_FAULT) |=> (rdata_out[4] == 1'b0) && (rdata_out[2:0] == 3'h0))
        else $error("reserved fault bits not zero");

    unmapped_read_a: assert property (
        (req_in.rd && !hit) |=> rdata_out == 8'h00)
        else $error("read outside bases not zero");

    // ==========================================================
    // flags hold until a matching clear; closed paths idle low
    overtemp_hold_a: assert property (
        (fault_q[OT_BIT] && !(wr_fault && req_in.wdata[OT_BIT])) |=> fault_q[OT_BIT])
        else $error("overtemp flag lost without clear");

    dom_flag_set_a: assert property (
        sense_s.stuck_dom |=> fault_q[DOM_BIT])
        else $error("stuck dominant flag not set");

    rf_flag_hold_a: assert property (
        (fault_q[RF_BIT] && !(wr_fault && req_in.wdata[RF_BIT])) |=> fault_q[RF_BIT])
        else $error("rf disturbance flag lost without clear");

    uv_flag_hold_a: assert property (
        (fault_q[UV_BIT] && !(wr_fault && req_in.wdata[UV_BIT])) |=> fault_q[UV_BIT])
        else $error("undervoltage flag lost without clear");

    uart_tx_path_a: assert property (
        (tx_sel_q == 2'h1 && !uv_block) |=> lin_tx_out == $past(uart_tx_in))
        else $error("uart did not drive transmitter");

    tx_idle_a: assert property (
        (tx_sel_q == 2'h0) |=> !lin_tx_out)
        else $error("transmitter driven with no source");

    rx_port_path_a: assert property (
        (rx_sel_q == 2'h2) |=> (port_rx_out == $past(sense_s.rx_dom)) && !uart_rx_out)
        else $error("receiver not routed to port alone");

    rx_uart_path_a: assert property (
        (rx_sel_q == 2'h1) |=> (uart_rx_out == $past(sense_s.rx_dom)) && !port_rx_out)
        else $error("receiver not routed to uart alone");

    rx_port_off_a: assert property (
        !rx_sel_q[DST_PORT_BIT] |=> !port_rx_out)
        else $error("port receive path not closed");

    rx_uart_off_a: assert property (
        !rx_sel_q[DST_UART_BIT] |=> !uart_rx_out)
        else $error("uart receive path not closed");

    irq_overtemp_a: assert property (
        (fault_q[OT_BIT] && overtemp_irq_enable_in) |=> irq_out)
        else $error("overtemp interrupt missing");

    irq_dom_a: assert property (
        (fault_q[DOM_BIT] && stuck_dominant_irq_enable_in) |=> irq_out)
        else $error("stuck dominant interrupt missing");

    sel_reserved_a: assert property (
        (req_in.rd && hit && (ofs == OFS_TX_SEL || ofs == OFS_RX_SEL)) |=> rdata_out[7:2] == 6'h00)
        else $error("reserved select bits not zero");

endmodule // lin_phy_status_routing

`default_nettype wire

/* rtl/lin_phy_pkg.sv */
// package for the lin physical-layer status and routing register bank
// assumes one 100 mhz clock and an 8-bit register port with 16-bit global address
`default_nettype none

package lin_phy_pkg;

    // ==========================================================
    // address decode
    localparam logic [15:0] BLOCKING_BASE = 16'h0e00;
    localparam logic [15:0] NONBLOCKING_BASE = 16'h0f00;
    localparam logic [15:0] BASE_MASK = 16'hff00;
    localparam logic [7:0] OFS_FAULT = 8'h52;
    localparam logic [7:0] OFS_LINE = 8'h53;
    localparam logic [7:0] OFS_TX_SEL = 8'h54;
    localparam logic [7:0] OFS_RX_SEL = 8'h55;

    // ==========================================================
    // field positions
    localparam int OT_BIT = 7;
    localparam int DOM_BIT = 6;
    localparam int RF_BIT = 5;
    localparam int UV_BIT = 3;
    localparam int RDY_BIT = 7;
    localparam int RX_BIT = 1;
    localparam int TX_BIT = 0;
    localparam int SRC_PORT_BIT = 1;
    localparam int SRC_UART_BIT = 0;
    localparam int DST_PORT_BIT = 1;
    localparam int DST_UART_BIT = 0;

    // ==========================================================
    // reset values
    localparam logic [7:0] FAULT_RESET = 8'h00;
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    // transceiver sense lines, all asynchronous, dominant reads as one
    typedef struct packed {
        logic overtemp;
        logic stuck_dom;
        logic rf_dist;
        logic undervolt;
        logic tx_ready;
        logic rx_dom;
        logic tx_dom;
    } phy_sense_type;

    localparam int SENSE_W = $bits(phy_sense_type);

endpackage

`default_nettype wire

/* rtl/level_sync.sv */
// two-flop synchroniser for a group of asynchronous levels
// assumes the levels are slow against ref_clk_in; no word coherence across bits
`default_nettype none
`timescale 1ns/100ps

module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ==========================================================
    // first stage feeds only the second
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule // level_sync

`default_nettype wire

/* bench/uart_port_model.sv */
// far-side model: uart and general port driving transmit levels
// assumes one shared ref_clk_in; levels change right after each rising edge
`default_nettype none
`timescale 1ns/100ps

module uart_port_model (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    output logic port_tx_out,
    output logic uart_tx_out
);
    // ==========================================================
    // transmit pattern
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;

    // levels differ in two of every four cycles, so a wrong source shows quickly
    always_comb begin
        cnt_d = cnt_q + 2'h1;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // port pin set up as pass-through by software before use
    assign port_tx_out = cnt_q[0];
    assign uart_tx_out = cnt_q[1];
endmodule // uart_port_model

`default_nettype wire

/* bench/lin_phy_status_routing_test.sv */
// self-checking bench for the lin status and routing register bank
// assumes the far-side model shares ref_clk_in; sense lines driven here
`default_nettype none
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module lin_phy_status_routing_test
    import lin_phy_pkg::*;
;
    typedef struct packed {logic [15:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_type;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    reg_req_type req = '0;
    phy_sense_type sense = '0;
    logic overtemp_irq_enable = 1'b0, domie = 1'b0, keep = 1'b1;
    logic port_tx, uart_tx, pu, uu, port_rx, uart_rx, lin_tx, irq;
    logic [7:0] rdata;
    int errors = 0;
    int checked = 0;
    // unmapped, read-only and outside-page writes must read back zero
    row_type rows [7] = '{'{16'h0e54, 8'hff, 8'h03}, '{16'h0f55, 8'hfe, 8'h02},
        '{16'h0e53, 8'hff, 8'h00}, '{16'h0e56, 8'hff, 8'h00}, '{16'h0d54, 8'hff, 8'h00},
        '{16'h0f54, 8'h00, 8'h00}, '{16'h0e55, 8'h00, 8'h00}};

    // ==========================================================
    // clock, design and far side
    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    lin_phy_status_routing dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_in(req),
        .rdata_out(rdata), .sense_in(sense), .port_tx_in(port_tx), .uart_tx_in(uart_tx),
        .overtemp_irq_enable_in(overtemp_irq_enable), .stuck_dominant_irq_enable_in(domie),
        .low_supply_keep_alive_in(keep), .lin_tx_out(lin_tx), .port_rx_out(port_rx),
        .uart_rx_out(uart_rx), .irq_out(irq));

    uart_port_model far_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .port_tx_out(port_tx),
        .uart_tx_out(uart_tx));

    // ==========================================================
    // register port tasks
    task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_in);
        req.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_check(input logic [15:0] a, input logic [7:0] e);
        @(posedge ref_clk_in);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_in);
        req.rd <= 1'b0;
        @(negedge ref_clk_in);
        `CHK(rdata, e)
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #100us;
        errors++;
        print_verdict();
    end

    // ==========================================================
    // tests
    initial begin
        repeat (16) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(negedge ref_clk_in);
        `CHK(lin_tx, 1'b0)
        reg_check(16'h0e52, 8'h00);
        reg_check(16'h0f54, 8'h00);
        reg_check(16'h0e55, 8'h00);
        foreach (rows[i]) begin
            reg_write(rows[i].addr, rows[i].wdata);
            reg_check(rows[i].addr, rows[i].exp);
        end
        @(posedge ref_clk_in);
        sense <= 7'h02;
        for (int i = 0; i < 16; i++) begin
            reg_write(16'h0e54, {6'h00, i[1:0]});
            reg_write(16'h0f55, {6'h00, i[3:2]});
            settle(5);
            for (int k = 0; k < 3; k++) begin
                pu = port_tx;
                uu = uart_tx;
                @(negedge ref_clk_in);
                `CHK(lin_tx, logic'(i[0] ? uu : (i[1] & pu)))
                `CHK(port_rx, logic'(i[3]))
                `CHK(uart_rx, logic'(i[2]))
            end
        end
        @(posedge ref_clk_in);
        sense <= 7'h7f;
        settle(6);
        reg_check(16'h0e52, 8'he8);
        reg_check(16'h0e53, 8'h83);
        // clear while the condition persists: flags set again
        reg_write(16'h0e52, 8'hff);
        reg_check(16'h0f52, 8'he8);
        @(posedge ref_clk_in);
        overtemp_irq_enable <= 1'b1;
        settle(3);
        `CHK(irq, 1'b1)
        @(posedge ref_clk_in);
        overtemp_irq_enable <= 1'b0;
        domie <= 1'b1;
        settle(3);
        `CHK(irq, 1'b1)
        @(posedge ref_clk_in);
        domie <= 1'b0;
        keep <= 1'b0;
        settle(3);
        `CHK(irq, 1'b0)
        for (int k = 0; k < 4; k++) begin
            @(negedge ref_clk_in);
            `CHK(lin_tx, 1'b0)
        end
        @(posedge ref_clk_in);
        sense <= 7'h00;
        keep <= 1'b1;
        settle(6);
        // both receive paths still open, receiver now recessive
        `CHK(port_rx, 1'b0)
        `CHK(uart_rx, 1'b0)
        reg_check(16'h0e53, 8'h00);
        reg_write(16'h0e52, 8'h20);
        reg_check(16'h0e52, 8'hc8);
        reg_write(16'h0f52, 8'h80);
        reg_check(16'h0e52, 8'h48);
        // stuck flag set but only the overtemp enable on: no interrupt
        @(posedge ref_clk_in);
        overtemp_irq_enable <= 1'b1;
        settle(3);
        `CHK(irq, 1'b0)
        reg_write(16'h0e52, 8'h40);
        reg_check(16'h0e52, 8'h08);
        reg_write(16'h0e52, 8'h08);
        reg_check(16'h0e52, 8'h00);
        // mid-run reset with flags, selects and interrupt live
        @(posedge ref_clk_in);
        sense <= 7'h7f;
        settle(6);
        @(posedge ref_clk_in);
        rst_in <= 1'b1;
        sense <= 7'h00;
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(negedge ref_clk_in);
        `CHK(lin_tx, 1'b0)
        `CHK(irq, 1'b0)
        reg_check(16'h0e52, 8'h00);
        reg_check(16'h0e54, 8'h00);
        reg_check(16'h0f55, 8'h00);
        print_verdict();
    end
endmodule // lin_phy_status_routing_test

`default_nettype wire
